// *** verilog/smm_defs.svh ***
// Constants for the management mode entry and exit controller
`ifndef SMM_DEFS_SVH
`define SMM_DEFS_SVH
`define SMM_OP_PREFIX     8'h0f
`define SMM_OP_RESUME     8'haa
`define SMM_FLAGS_ENTRY   32'h0000_0002
`define SMM_DR7_ENTRY     32'h0000_0400
`define SMM_IP_ENTRY      32'h0000_8000
`define SMM_CS_SEL_ENTRY  16'h3000
`define SMM_BASE_RESET    32'h0003_0000
`define SMM_LIMIT_4G      32'hffff_ffff
`define SMM_ALIGN_MSB     14
`define SMM_IO_RESTART    16'h00ff
`define SMM_CR0_PE        0
`define SMM_CR0_EM        2
`define SMM_CR0_TS        3
`define SMM_CR0_NW        29
`define SMM_CR0_CD        30
`define SMM_CR0_PG        31
`define SMM_ADDR_CTRL     12'h000
`define SMM_ADDR_STATUS   12'h004
`define SMM_ADDR_BASE     12'h008
`define SMM_CTRL_RESET    32'h0000_0001
`define SMM_CTRL_EN       0
`define SMM_ST_ACTIVE     0
`define SMM_ST_SHUTDOWN   1
`define SMM_ST_SMI_PEND   2
`define SMM_ST_NMI_PEND   3
`define SMM_ST_NMI_BLOCK  4
`endif

// *** verilog/smm_pkg.sv ***
// Types shared by the management mode controller
package smm_pkg;
   typedef enum logic [2:0] {
      ST_NORMAL, ST_DRAIN, ST_SAVE, ST_HANDLER, ST_RESTORE, ST_SHUTDOWN
   } smm_state_t;

   // Slots read back from the save area by the resume instruction
   typedef struct packed {
      logic [31:0] cr0;
      logic [31:0] dump_base;
      logic [15:0] halt_slot;
      logic [15:0] io_slot;
   } restore_image_t;

   // Core state forced on entry
   typedef struct packed {
      logic [31:0] flags;
      logic [31:0] dr7;
      logic [31:0] ip;
      logic [31:0] cr0;
      logic [15:0] cs_sel;
      logic [31:0] cs_base;
      logic [31:0] seg_base;
      logic [31:0] limit;
   } entry_state_t;
endpackage : smm_pkg

// *** verilog/sm_mode_entry_exit_control.sv ***
// Management mode entry, resume and shutdown control with APB status
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "smm_defs.svh"

// Notes on behaviour
// - Opcode 0F AA resumes in handler; outside the mode invalid opcode
// - Unaligned dump base on resume causes shutdown
// - Illegal control-register-zero combination causes shutdown
// - Shutdown cycle, halt until NMI or reset
// - Halt restart slot chooses halt re-entry
// - I/O restart slot re-executes trapped instruction
// - Resume loads region base from relocation slot
// - Reset also leaves management mode
// - Drain stores; last write ends on ready
// - Indicator, then state save, then handler fetch
// - Management interrupt beats debug and external
// - Latch one further request, serve after resume
// - Entry sets flags, debug control, pointer
// - Entry clears bits 0,2,3,31 of CR0
// - Entry sets segment selectors, bases, limits
// - Code selector always 3000h on entry
// - Handler fetch starts at offset 8000h
// - Sixteen-bit operand and address size inside
// - Selector load shifted left four into base
// - NMI blocked on entry, one latched
// - Interrupt return re-enables NMI inside mode
// - Hold, backoff and sizing inputs stay live
// - Indicator low means management memory accesses
module sm_mode_entry_exit_control (
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Interrupt sources and core events
   input  wire logic                   sm_interrupt_request,
   input  wire logic                   nmi_request,
   input  wire logic                   debug_exc_pending,
   input  wire logic                   ext_int_pending,
   input  wire logic                   instr_boundary,
   input  wire logic                   in_halt,
   input  wire logic                   opcode_valid,
   input  wire logic [15:0]            opcode,
   input  wire logic                   interrupt_return_instruction_exec,
   input  wire logic [31:0]            cr0_in,
   input  wire logic                   seg_load_valid,
   input  wire logic [15:0]            seg_load_value,
   // Store drain
   input  wire logic                   stores_pending,
   input  wire logic                   write_cycle_open,
   input  wire logic                   nonburst_ready,
   input  wire logic                   burst_ready,
   // State save and restore engine
   output logic                        save_req,
   input  wire logic                   save_done,
   output logic                        restore_req,
   input  wire logic                   restore_done,
   input  wire smm_pkg::restore_image_t restore_image,
   // Bus arbitration and sizing
   input  wire logic                   bus_hold_request,
   input  wire logic                   address_hold_request,
   input  wire logic                   backoff_input,
   input  wire logic                   bus_size_8,
   input  wire logic                   bus_size_16,
   output logic                        bus_stall,
   output logic [1:0]                  bus_width,
   // Results to the core and system
   output logic                        sm_active_indicator_n,
   output smm_pkg::entry_state_t       entry_state,
   output logic [31:0]                 seg_base_out,
   output logic                        default_size16,
   output logic                        fetch_start,
   output logic [31:0]                 fetch_addr,
   output logic                        invalid_opcode,
   output logic                        shutdown_cycle,
   output logic                        halted,
   output logic                        take_debug,
   output logic                        take_ext_int,
   output logic                        take_nmi,
   output logic                        resume_done,
   output logic                        restart_halt,
   output logic                        restart_io,
   output logic [31:0]                 sm_region_base
);
   import smm_pkg::*;

   smm_state_t state_ff, nxt_state;
   logic [31:0] ctrl_ff;
   logic        smi_pend_ff;
   logic        nmi_pend_ff;
   logic        nmi_block_ff;
   logic        halt_at_entry_ff;
   logic        write_ok;
   logic        drained;
   logic        smi_take;
   logic        resume_op;
   logic        bad_image;
   logic        in_mode;
   logic [31:0] status;

   assign in_mode   = state_ff inside {ST_SAVE, ST_HANDLER, ST_RESTORE};
   assign resume_op = opcode_valid
                    && opcode == {`SMM_OP_PREFIX, `SMM_OP_RESUME};
   // A last write still on the bus ends only on a ready strobe
   assign write_ok  = !write_cycle_open || nonburst_ready || burst_ready;
   assign drained   = !stores_pending && write_ok;
   assign smi_take  = state_ff == ST_NORMAL && instr_boundary
                    && (sm_interrupt_request || smi_pend_ff)
                    && ctrl_ff[`SMM_CTRL_EN];
   assign bad_image = restore_image.dump_base[`SMM_ALIGN_MSB:0] != '0
      || (restore_image.cr0[`SMM_CR0_PG]
          && !restore_image.cr0[`SMM_CR0_PE])
      || (restore_image.cr0[`SMM_CR0_NW]
          && !restore_image.cr0[`SMM_CR0_CD]);

   // Mode sequencing
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_NORMAL:   if (smi_take) nxt_state = ST_DRAIN;
         ST_DRAIN:    if (drained) nxt_state = ST_SAVE;
         ST_SAVE:     if (save_done) nxt_state = ST_HANDLER;
         ST_HANDLER:  if (resume_op) nxt_state = ST_RESTORE;
         ST_RESTORE: begin
            if (restore_done) begin
               nxt_state = bad_image ? ST_SHUTDOWN : ST_NORMAL;
            end
         end
         ST_SHUTDOWN: if (nmi_request) nxt_state = ST_NORMAL;
         default:     nxt_state = ST_NORMAL;
      endcase
   end

   // Reset drops any mode, the resume instruction is not needed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_NORMAL;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // One further request latched while busy; one raised in the take cycle is not kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smi_pend_ff <= 1'b0;
      end else if (sm_interrupt_request && state_ff != ST_NORMAL) begin
         smi_pend_ff <= 1'b1;
      end else if (smi_take) begin
         smi_pend_ff <= 1'b0;
      end
   end

   // NMI blocked on entry until an interrupt return or the return to normal state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_block_ff <= 1'b0;
      end else if (state_ff == ST_DRAIN && drained) begin
         nmi_block_ff <= 1'b1;
      end else if (state_ff == ST_HANDLER && interrupt_return_instruction_exec) begin
         nmi_block_ff <= 1'b0;
      end else if (state_ff == ST_NORMAL) begin
         nmi_block_ff <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pend_ff <= 1'b0;
      end else if (nmi_request && nmi_block_ff && in_mode) begin
         nmi_pend_ff <= 1'b1;
      end else if (take_nmi) begin
         nmi_pend_ff <= 1'b0;
      end
   end

   // Latched NMI served at exit, ahead of the interrupted program
   assign take_nmi = (nmi_pend_ff && state_ff == ST_NORMAL)
      || (nmi_request && !nmi_block_ff && state_ff != ST_SHUTDOWN)
      || (nmi_request && state_ff == ST_SHUTDOWN);
   assign take_debug   = instr_boundary && debug_exc_pending
                       && !smi_take;
   assign take_ext_int = instr_boundary && ext_int_pending
                       && !smi_take;

   // Handshakes with the save and restore engine
   assign save_req    = state_ff == ST_SAVE;
   assign restore_req = state_ff == ST_RESTORE;
   assign halted      = state_ff == ST_SHUTDOWN;

   // Arbitration and sizing pass straight through in every mode
   assign bus_stall = bus_hold_request || address_hold_request
                    || backoff_input;
   assign bus_width = bus_size_8 ? 2'd0 : (bus_size_16 ? 2'd1 : 2'd2);

   // Indicator low from drain end until restore completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sm_active_indicator_n <= 1'b1;
      end else if (state_ff == ST_DRAIN && drained) begin
         sm_active_indicator_n <= 1'b0;
      end else if (state_ff == ST_RESTORE && restore_done) begin
         sm_active_indicator_n <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_at_entry_ff <= 1'b0;
      end else if (smi_take) begin
         halt_at_entry_ff <= in_halt;
      end
   end

   // Entry state load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         entry_state <= '0;
      end else if (state_ff == ST_SAVE && save_done) begin
         entry_state.flags    <= `SMM_FLAGS_ENTRY;
         entry_state.dr7      <= `SMM_DR7_ENTRY;
         entry_state.ip       <= `SMM_IP_ENTRY;
         entry_state.cr0      <= cr0_in & ~((32'h1 << `SMM_CR0_PE)
                               | (32'h1 << `SMM_CR0_EM)
                               | (32'h1 << `SMM_CR0_TS)
                               | (32'h1 << `SMM_CR0_PG));
         entry_state.cs_sel   <= `SMM_CS_SEL_ENTRY;
         entry_state.cs_base  <= sm_region_base;
         entry_state.seg_base <= '0;
         entry_state.limit    <= `SMM_LIMIT_4G;
      end
   end

   // Real-mode style base from a selector load inside the mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seg_base_out <= '0;
      end else if (seg_load_valid && in_mode) begin
         seg_base_out <= {12'h000, seg_load_value, 4'h0};
      end
   end
   assign default_size16 = in_mode;

   // Handler fetch begins at the entry pointer in the code segment
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_start <= 1'b0;
         fetch_addr  <= '0;
      end else begin
         fetch_start <= state_ff == ST_SAVE && save_done;
         if (state_ff == ST_SAVE && save_done) begin
            fetch_addr <= sm_region_base + `SMM_IP_ENTRY;
         end
      end
   end

   // Resume results and region relocation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume_done    <= 1'b0;
         restart_halt   <= 1'b0;
         restart_io     <= 1'b0;
         sm_region_base <= `SMM_BASE_RESET;
      end else begin
         resume_done <= state_ff == ST_RESTORE && restore_done
                        && !bad_image;
         if (state_ff == ST_RESTORE && restore_done && !bad_image) begin
            restart_halt   <= halt_at_entry_ff
                              && restore_image.halt_slot[0];
            restart_io     <= restore_image.io_slot
                              == `SMM_IO_RESTART;
            sm_region_base <= restore_image.dump_base;
         end
      end
   end

   // Fault pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         invalid_opcode <= 1'b0;
         shutdown_cycle <= 1'b0;
      end else begin
         invalid_opcode <= resume_op && !in_mode;
         shutdown_cycle <= state_ff == ST_RESTORE && restore_done
                           && bad_image;
      end
   end

   // APB slave: zero wait states, read data captured in setup
   assign pready = 1'b1;
   assign status = {27'h0, nmi_block_ff, nmi_pend_ff, smi_pend_ff,
                    state_ff == ST_SHUTDOWN, in_mode};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `SMM_CTRL_RESET;
      end else if (psel && penable && pwrite
                   && paddr == `SMM_ADDR_CTRL) begin
         ctrl_ff <= {31'h0, pwdata[`SMM_CTRL_EN]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         prdata  <= '0;
         if (paddr == `SMM_ADDR_CTRL) begin
            prdata <= ctrl_ff;
         end else if (paddr == `SMM_ADDR_STATUS) begin
            prdata <= status;
            pslverr <= pwrite;
         end else if (paddr == `SMM_ADDR_BASE) begin
            prdata <= sm_region_base;
            pslverr <= pwrite;
         end else begin
            pslverr <= 1'b1;
         end
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_entry;
      state_ff == ST_DRAIN && drained;
   endsequence
   sequence s_saved;
      state_ff == ST_SAVE && save_done;
   endsequence

   a_entry_indicator: assert property (s_entry |=> !sm_active_indicator_n)
      else $error("indicator not active after drain");
   a_save_waits_drain: assert property (
      state_ff == ST_DRAIN && !drained |=> state_ff == ST_DRAIN)
      else $error("left drain with stores pending");
   a_fetch_after_save: assert property (s_saved |=> fetch_start
      && fetch_addr == sm_region_base + 32'h0000_8000)
      else $error("handler fetch wrong");
   a_entry_regs: assert property (s_saved |=> entry_state.flags == 32'h2
      && entry_state.dr7 == 32'h400 && entry_state.cs_sel == 16'h3000
      && !entry_state.cr0[31] && !entry_state.cr0[0])
      else $error("entry state wrong");
   a_smi_priority: assert property (smi_take |-> !take_debug
      && !take_ext_int)
      else $error("lower priority event taken with management request");
   a_bad_shutdown: assert property (state_ff == ST_RESTORE && restore_done
      && bad_image |=> state_ff == ST_SHUTDOWN && shutdown_cycle)
      else $error("bad image did not shut down");
   a_outside_resume: assert property (resume_op && !in_mode
      |=> invalid_opcode && $stable(sm_active_indicator_n))
      else $error("resume outside mode not refused");
   a_exit_indicator: assert property (state_ff == ST_RESTORE && restore_done
      |=> sm_active_indicator_n)
      else $error("indicator still active after restore");
   a_nmi_blocked: assert property (in_mode && nmi_block_ff |-> !take_nmi)
      else $error("nmi taken while blocked");
   a_seg_shift: assert property (seg_load_valid && in_mode
      |=> seg_base_out == {12'h0, $past(seg_load_value), 4'h0})
      else $error("segment base not shifted");
endmodule : sm_mode_entry_exit_control

// *** dv/smm_chipset_model.sv ***
// Chipset side: store drain traffic and state save/restore engine
`timescale 1ns/1ps
module smm_chipset_model (
   // Clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // Save and restore engine
   input  wire logic                    save_req,
   input  wire logic                    restore_req,
   input  wire smm_pkg::restore_image_t img,
   output logic                         save_done,
   output logic                         restore_done,
   output smm_pkg::restore_image_t      restore_image,
   // Store traffic
   output logic                         stores_pending,
   output logic                         write_cycle_open,
   output logic                         nonburst_ready,
   output logic                         burst_ready
);
   import smm_pkg::*;
   logic [2:0] phase_ff;
   logic [2:0] wait_ff;
   logic       alt_ff;
   logic       slow_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= 3'h0;
         alt_ff   <= 1'b0;
      end else begin
         phase_ff <= phase_ff + 3'h1;
         if (phase_ff == 3'h5) alt_ff <= ~alt_ff;
      end
   end
   assign stores_pending   = phase_ff < 3'h3;
   assign write_cycle_open = phase_ff >= 3'h3 && phase_ff <= 3'h5;
   // Open write ends on either ready strobe in turn
   assign burst_ready      = phase_ff == 3'h5 && alt_ff;
   assign nonburst_ready   = phase_ff == 3'h5 && !alt_ff;
   // Engine answers promptly and slowly in turn
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_ff <= 3'h0;
         slow_ff <= 1'b0;
      end else if (save_done || restore_done) begin
         wait_ff <= 3'h0;
         slow_ff <= ~slow_ff;
      end else if (save_req || restore_req) wait_ff <= wait_ff + 3'h1;
   end
   assign save_done    = save_req && wait_ff == (slow_ff ? 3'h5 : 3'h1);
   assign restore_done = restore_req && wait_ff == (slow_ff ? 3'h5 : 3'h1);
   // Released image bus shows the inverse, not the last value
   assign restore_image = restore_req ? img : ~img;
endmodule : smm_chipset_model

// *** dv/sm_mode_entry_exit_control_test.sv ***
// Testbench for the management mode entry and exit controller
`timescale 1ns/1ps
module sm_mode_entry_exit_control_test;
   import smm_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, sm_interrupt_request = 1'b0, nmi_request = 1'b0;
   logic debug_exc_pending = 1'b0, ext_int_pending = 1'b0, in_halt = 1'b0;
   logic instr_boundary = 1'b0, opcode_valid = 1'b0, interrupt_return_instruction_exec = 1'b0;
   logic seg_load_valid = 1'b0, bus_hold_request = 1'b0, backoff_input = 1'b0;
   logic address_hold_request = 1'b0, bus_size_8 = 1'b0, bus_size_16 = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [15:0] opcode = 16'h0000, seg_load_value = 16'h0000;
   logic [31:0] pwdata = 32'h0, cr0_in = 32'hffff_ffff;
   logic [31:0] prdata, fetch_addr, seg_base_out, sm_region_base, rd;
   logic pready, pslverr, stores_pending, write_cycle_open, nonburst_ready;
   logic burst_ready, save_req, save_done, restore_req, restore_done, err;
   logic bus_stall, sm_active_indicator_n, default_size16, fetch_start;
   logic invalid_opcode, shutdown_cycle, halted, take_debug, take_ext_int;
   logic take_nmi, resume_done, restart_halt, restart_io;
   logic [1:0] bus_width;
   restore_image_t restore_image, img = '0;
   entry_state_t entry_state;
   // Dump base off 32K, PG without PE, NW without CD
   restore_image_t bad [3] = '{{32'h0000_0011, 32'h0004_8100, 32'h0},
      {32'h8000_0010, 32'h0004_8000, 32'h0},
      {32'h2000_0011, 32'h0004_8000, 32'h0}};
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n_inv = 0, n_fetch = 0;
   int n_res = 0, n_shut = 0, n_nmi = 0, n_side = 0;

   always #20 pclk = ~pclk;

   sm_mode_entry_exit_control dut_u (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sm_interrupt_request, .nmi_request, .debug_exc_pending,
      .ext_int_pending, .instr_boundary, .in_halt, .opcode_valid, .opcode,
      .interrupt_return_instruction_exec, .cr0_in, .seg_load_valid, .seg_load_value,
      .stores_pending, .write_cycle_open, .nonburst_ready, .burst_ready,
      .save_req, .save_done, .restore_req, .restore_done, .restore_image,
      .bus_hold_request, .address_hold_request, .backoff_input, .bus_size_8,
      .bus_size_16, .bus_stall, .bus_width, .sm_active_indicator_n,
      .entry_state, .seg_base_out, .default_size16, .fetch_start,
      .fetch_addr, .invalid_opcode, .shutdown_cycle, .halted, .take_debug,
      .take_ext_int, .take_nmi, .resume_done, .restart_halt, .restart_io,
      .sm_region_base);
   smm_chipset_model far_u (.pclk, .presetn, .save_req, .restore_req, .img,
      .save_done, .restore_done, .restore_image, .stores_pending,
      .write_cycle_open, .nonburst_ready, .burst_ready);

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task tally_and_finish;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // Pulses counted at the falling edge, where outputs have settled
   always @(negedge pclk) begin
      cyc++;
      n_inv += int'(invalid_opcode === 1'b1);
      n_fetch += int'(fetch_start === 1'b1);
      n_res += int'(resume_done === 1'b1);
      n_shut += int'(shutdown_cycle === 1'b1);
      n_nmi += int'(take_nmi === 1'b1);
      n_side += int'(take_debug === 1'b1) + int'(take_ext_int === 1'b1);
      if (save_req === 1'b1) chk(sm_active_indicator_n, 0);
      if (cyc == 6000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task enter(input logic req, input logic side);
      int t;
      t = n_fetch;
      @(posedge pclk);
      sm_interrupt_request <= req;
      instr_boundary <= 1'b1;
      debug_exc_pending <= side;
      ext_int_pending <= side;
      @(posedge pclk);
      sm_interrupt_request <= 1'b0;
      instr_boundary <= 1'b0;
      debug_exc_pending <= 1'b0;
      ext_int_pending <= 1'b0;
      repeat (40) if (n_fetch == t) @(posedge pclk);
      chk(n_fetch, t + 1);
   endtask : enter

   task resume(input restore_image_t im);
      int t;
      t = n_res + n_shut;
      img <= im;
      @(posedge pclk);
      opcode_valid <= 1'b1;
      opcode <= 16'h0faa;
      @(posedge pclk);
      opcode_valid <= 1'b0;
      opcode <= 16'h0000;
      repeat (20) if (n_res + n_shut == t) @(posedge pclk);
   endtask : resume

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h000, 0);
      chk(rd, 32'h1);
      apb(0, 12'h008, 0);
      chk(rd, 32'h0003_0000);
      apb(1, 12'h008, 0);
      chk(err, 1);
      apb(0, 12'h00c, 0);
      chk(err, 1);
      apb(1, 12'h000, 32'h0);
      apb(0, 12'h000, 0);
      chk(rd, 32'h0);
      // Disabled request leaves debug and external events to be taken
      @(posedge pclk);
      {sm_interrupt_request, instr_boundary} <= 2'h3;
      {debug_exc_pending, ext_int_pending} <= 2'h3;
      @(posedge pclk);
      {sm_interrupt_request, instr_boundary} <= 2'h0;
      {debug_exc_pending, ext_int_pending} <= 2'h0;
      repeat (10) @(posedge pclk);
      chk(n_fetch, 0);
      chk(n_side, 2);
      apb(1, 12'h000, 32'h1);
      chk(err, 0);
      chk(sm_active_indicator_n, 1);
      chk(default_size16, 0);
      $display("test registers done");
      resume('0);
      chk(n_inv, 1);
      chk(n_res + n_shut, 0);
      $display("test stray resume done");
      in_halt <= 1'b1;
      enter(1'b1, 1'b1);
      in_halt <= 1'b0;
      chk(n_side, 2);
      chk(sm_active_indicator_n, 0);
      chk(entry_state.flags, 32'h0000_0002);
      chk(entry_state.dr7, 32'h0000_0400);
      chk(entry_state.ip, 32'h0000_8000);
      chk(entry_state.cr0, 32'h7fff_fff2);
      chk(entry_state.cs_sel, 32'h3000);
      chk(entry_state.cs_base, 32'h0003_0000);
      chk(entry_state.seg_base, 0);
      chk(entry_state.limit, 32'hffff_ffff);
      chk(fetch_addr, 32'h0003_8000);
      chk(default_size16, 1);
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         {bus_hold_request, address_hold_request, backoff_input} <= 3'h1 << i;
         bus_size_8 <= i == 1;
         bus_size_16 <= i == 2;
         @(negedge pclk);
         chk(bus_stall, i < 3);
         chk(bus_width, i == 1 ? 0 : i == 2 ? 1 : 2);
      end
      @(posedge pclk);
      seg_load_valid <= 1'b1;
      seg_load_value <= 16'h1234;
      @(posedge pclk);
      seg_load_valid <= 1'b0;
      @(negedge pclk);
      chk(seg_base_out, 32'h0001_2340);
      repeat (2) begin
         @(posedge pclk);
         {sm_interrupt_request, instr_boundary, nmi_request} <= 3'h7;
         @(posedge pclk);
         {sm_interrupt_request, instr_boundary, nmi_request} <= 3'h0;
      end
      chk(n_fetch, 1);
      chk(n_nmi, 0);
      apb(0, 12'h004, 0);
      chk(rd, 32'h1d);
      resume({32'h0000_0011, 32'h0004_8000, 16'h0001, 16'h00ff});
      chk(n_res, 1);
      chk(n_inv, 1);
      chk(restart_halt, 1);
      chk(restart_io, 1);
      chk(sm_region_base, 32'h0004_8000);
      repeat (3) @(posedge pclk);
      chk(n_nmi, 1);
      chk(sm_active_indicator_n, 1);
      $display("test entry and resume done");
      in_halt <= 1'b1;
      cr0_in <= 32'h6000_001d;
      enter(1'b0, 1'b0);
      in_halt <= 1'b0;
      chk(fetch_addr, 32'h0005_0000);
      chk(entry_state.cr0, 32'h6000_0010);
      chk(entry_state.cs_sel, 32'h3000);
      @(posedge pclk);
      interrupt_return_instruction_exec <= 1'b1;
      @(posedge pclk);
      interrupt_return_instruction_exec <= 1'b0;
      nmi_request <= 1'b1;
      @(posedge pclk);
      nmi_request <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(n_nmi, 2);
      resume({32'h0000_0011, 32'h0004_8000, 32'h0});
      chk(restart_halt, 0);
      chk(restart_io, 0);
      $display("test latched request done");
      for (int k = 0; k < 3; k++) begin
         enter(1'b1, 1'b0);
         resume(bad[k]);
         chk(n_shut, k + 1);
         chk(halted, 1);
         @(posedge pclk);
         nmi_request <= 1'b1;
         @(posedge pclk);
         nmi_request <= 1'b0;
         @(negedge pclk);
         chk(halted, 0);
      end
      $display("test shutdown done");
      enter(1'b1, 1'b0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(sm_active_indicator_n, 1);
      chk(sm_region_base, 32'h0003_0000);
      chk(default_size16, 0);
      $display("test reset exit done");
      tally_and_finish();
   end
endmodule : sm_mode_entry_exit_control_test
